// file: design/smt_master.sv
// SMBus master: drives clock, runs write and read transfers for a user
module smt_master #(
	parameter int HALF_CYC = smt_pkg::SCL_HALF_CYC
) (
	input wire logic ref_clk, // 40 MHz clock
	input wire logic arst_n, // Async reset
	smt_bus_if.master bus, // Two-wire bus
	input wire logic req, // Start a transfer (pulse)
	input wire logic [6:0] req_addr, // Target address
	input wire logic req_rd, // 1 = read one byte
	input wire logic [1:0] req_nbytes, // Write bytes, 1 or 2
	input wire logic req_rstart, // End with repeated start
	input wire logic [7:0] req_b0, // Pointer byte
	input wire logic [7:0] req_b1, // Data byte
	output logic busy, // Transfer in progress
	output logic done, // Transfer finished (pulse)
	output logic nack, // Some byte not acknowledged
	output logic [7:0] rdata // Byte read by a read; holds req_b0 after a write
);
	typedef enum logic [2:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP, MS_RS} smt_mst_e;
	smt_mst_e st_q, st_d;
	logic [7:0] div_q, div_d;
	logic [1:0] ph_q, ph_d;
	logic [3:0] bit_q, bit_d;
	logic [1:0] idx_q, idx_d, nb_q, nb_d;
	logic [7:0] sh_q, sh_d, rd_q, rd_d;
	logic rdm_q, rdm_d, rs_q, rs_d, nack_q, nack_d, done_q, done_d;
	logic busy_q, busy_d;
	logic scl_q, scl_d, sdao_q, sdao_d;
	logic [7:0] b1_q, b1_d;
	logic [1:0] sda_s_q;
	logic tick;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			sda_s_q <= 2'h3;
		else
			sda_s_q <= {sda_s_q[0], bus.sda};
	end
	assign tick = div_q == 8'(HALF_CYC / 2 - 1);

	// Quarter-period phases: 0 low-set data, 1 rise, 2 sample, 3 fall
	always_comb begin
		st_d = st_q;
		div_d = tick ? 8'h00 : div_q + 8'h01;
		ph_d = ph_q;
		bit_d = bit_q;
		idx_d = idx_q;
		nb_d = nb_q;
		sh_d = sh_q;
		rd_d = rd_q;
		rdm_d = rdm_q;
		rs_d = rs_q;
		nack_d = nack_q;
		done_d = 1'b0;
		scl_d = scl_q;
		sdao_d = sdao_q;
		b1_d = b1_q;
		if (st_q == MS_IDLE) begin
			div_d = 8'h00;
			if (req) begin
				st_d = MS_START;
				ph_d = 2'h0;
				sh_d = {req_addr, req_rd};
				rdm_d = req_rd;
				rs_d = req_rstart;
				nb_d = req_rd ? 2'h1 : req_nbytes;
				idx_d = 2'h0;
				b1_d = req_b1;
				rd_d = req_b0;
				nack_d = 1'b0;
			end
		end else if (tick) begin
			ph_d = ph_q + 2'h1;
			unique case (st_q)
				MS_START: begin
					if (ph_q == 2'h0)
						sdao_d = 1'b1;
					else if (ph_q == 2'h1)
						scl_d = 1'b1;
					else if (ph_q == 2'h2)
						sdao_d = 1'b0;
					else begin
						scl_d = 1'b0;
						st_d = MS_BIT;
						bit_d = 4'h0;
					end
				end
				MS_BIT: begin
					if (ph_q == 2'h0) begin
						if (bit_q < 4'h8)
							sdao_d = (rdm_q && idx_q != 2'h0) ? 1'b1 : sh_q[7];
						else
							sdao_d = !(rdm_q && idx_q != 2'h0) || 1'b1; // RQ9
						if (bit_q == 4'h8 && !(rdm_q && idx_q != 2'h0))
							sdao_d = 1'b1;
					end else if (ph_q == 2'h1)
						scl_d = 1'b1;
					else if (ph_q == 2'h2) begin
						if (bit_q < 4'h8)
							sh_d = {sh_q[6:0], sda_s_q[1]};
						else if (!(rdm_q && idx_q != 2'h0) && sda_s_q[1])
							nack_d = 1'b1;
					end else begin
						scl_d = 1'b0;
						bit_d = bit_q + 4'h1;
						if (bit_q == 4'h8) begin
							bit_d = 4'h0;
							if (rdm_q && idx_q != 2'h0)
								rd_d = sh_q;
							if (nack_q || idx_q == nb_q)
								st_d = rs_q ? MS_RS : MS_STOP;
							else begin
								idx_d = idx_q + 2'h1;
								sh_d = rdm_q ? 8'hFF : (idx_q == 2'h0 ? rd_q : b1_q);
							end
						end
					end
				end
				MS_STOP, MS_RS: begin
					if (ph_q == 2'h0)
						sdao_d = st_q == MS_RS; // RQ8 RQ9
					else if (ph_q == 2'h1)
						scl_d = 1'b1;
					else if (ph_q == 2'h2)
						sdao_d = 1'b1;
					else begin
						st_d = MS_IDLE;
						done_d = 1'b1;
					end
				end
				default: ;
			endcase
		end
		busy_d = st_d != MS_IDLE;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= MS_IDLE;
			div_q <= 8'h00;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			idx_q <= 2'h0;
			nb_q <= 2'h0;
			sh_q <= 8'h00;
			rd_q <= 8'h00;
			rdm_q <= 1'b0;
			rs_q <= 1'b0;
			nack_q <= 1'b0;
			done_q <= 1'b0;
			busy_q <= 1'b0;
			scl_q <= 1'b1;
			sdao_q <= 1'b1;
			b1_q <= 8'h00;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			ph_q <= ph_d;
			bit_q <= bit_d;
			idx_q <= idx_d;
			nb_q <= nb_d;
			sh_q <= sh_d;
			rd_q <= rd_d;
			rdm_q <= rdm_d;
			rs_q <= rs_d;
			nack_q <= nack_d;
			done_q <= done_d;
			busy_q <= busy_d;
			scl_q <= scl_d;
			sdao_q <= sdao_d;
			b1_q <= b1_d;
		end
	end

	assign bus.scl_o = scl_q;
	assign bus.scl_oe = !scl_q;
	assign bus.sda_m_o = 1'b0;
	assign bus.sda_m_oe = !sdao_q;
	assign busy = busy_q;
	assign done = done_q;
	assign nack = nack_q;
	assign rdata = rd_q;
endmodule

// file: design/smt_target.sv
// SMBus target: address select, pointer and register write/read port
// Operation
// [RQ1] Base variant answers fixed address 0x2E
// [RQ2] Strap high gives 0x2E, low selects strap mode
// [RQ3] Strap mode: second strap picks 0x2C/0x2D
// [RQ4] Straps sampled once at power-up
// [RQ5] Address locked at eighth clock of match
// [RQ6] Nine clocks per byte, receiver acknowledges
// [RQ7] Data changes only while clock low
// [RQ8] Master stops after write in tenth clock
// [RQ9] Master not-acknowledges read then stops
// [RQ10] Direction fixed for whole transfer
// [RQ11] Writes of one or two bytes, reads one
// [RQ12] First write byte loads register pointer
// [RQ13] Second write byte stored to pointed register
// [RQ14] Write: pointer then data
// [RQ15] Pointer-only write modifies no register
// [RQ16] Read returns pointed register, no pointer needed
// [RQ17] Pointer write, repeated start, read supported
// [RQ18] Repeated start begins new transfer
// [RQ19] All register access via serial bus
// [RQ20] 35 ms inactivity abandons transfer, releases line
// [RQ21] Timeout disabled by config bit six
// [RQ22] No acknowledge for foreign address
// [RQ23] Pointer kept between transfers
module smt_target #(
	parameter bit SELECTABLE = 1'b0,
	parameter int TIMEOUT_CYC = smt_pkg::TIMEOUT_CYC
) (
	input wire logic ref_clk, // 40 MHz clock
	input wire logic arst_n, // Async reset
	smt_bus_if.target bus, // Two-wire bus
	input wire logic address_strap_enable, // Strap: high = fixed address
	input wire logic addr_select_strap, // Strap: picks 0x2C/0x2D
	input wire logic [7:0] reg_rdata, // Data of pointed register
	output logic [7:0] reg_ptr, // Register pointer
	output logic reg_wr, // Register write pulse
	output logic [7:0] reg_wdata, // Register write data
	output logic [6:0] own_addr // Selected target address
);
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WRX, ST_ACK, ST_TX, ST_RACK, ST_IGN}
		smt_state_e;
	logic [1:0] scl_s_q, sda_s_q;
	logic scl_p_q, sda_p_q;
	logic [1:0] strap_s_q, strap2_s_q;
	logic strap_done_q, locked_q, strap_mode_q, strap_lvl_q;
	logic [1:0] strap_cnt_q;
	logic [6:0] addr_q, addr_d;
	logic locked_d;
	smt_state_e st_q, st_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d;
	logic [1:0] nbyte_q, nbyte_d;
	logic rd_q, rd_d;
	logic sda_oe_q, sda_oe_d;
	logic [7:0] ptr_q, ptr_d, wdata_q, wdata_d;
	logic wr_q, wr_d, tmo_off_q, tmo_off_d;
	logic [31:0] idle_q, idle_d;
	logic scl, sda, rise, fall, start_c, stop_c;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			strap_s_q <= 2'h0;
			strap2_s_q <= 2'h0;
		end else begin
			scl_s_q <= {scl_s_q[0], bus.scl};
			sda_s_q <= {sda_s_q[0], bus.sda};
			scl_p_q <= scl_s_q[1];
			sda_p_q <= sda_s_q[1];
			strap_s_q <= {strap_s_q[0], address_strap_enable};
			strap2_s_q <= {strap2_s_q[0], addr_select_strap};
		end
	end
	assign scl = scl_s_q[1];
	assign sda = sda_s_q[1];
	assign rise = scl && !scl_p_q;
	assign fall = !scl && scl_p_q;
	assign start_c = scl && scl_p_q && !sda && sda_p_q; // RQ18
	assign stop_c = scl && scl_p_q && sda && !sda_p_q; // RQ7

	// Straps caught once after reset release, when the synchronisers hold pin levels
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_cnt_q <= 2'h0;
			strap_done_q <= 1'b0;
			strap_mode_q <= 1'b0;
			strap_lvl_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_cnt_q == 2'h2) begin
				strap_done_q <= 1'b1; // RQ4
				strap_mode_q <= SELECTABLE && !strap_s_q[1]; // RQ2
				strap_lvl_q <= strap2_s_q[1];
			end
		end
	end

	always_comb begin
		addr_d = addr_q;
		if (!locked_q)
			addr_d = !strap_mode_q ? smt_pkg::ADDR_FIXED : // RQ1 RQ2
				(strap_lvl_q ? smt_pkg::ADDR_SEL_HI : smt_pkg::ADDR_SEL_LO); // RQ3
	end

	always_comb begin
		st_d = st_q;
		bit_d = bit_q;
		sh_d = sh_q;
		nbyte_d = nbyte_q;
		rd_d = rd_q;
		sda_oe_d = sda_oe_q;
		ptr_d = ptr_q; // RQ23
		wdata_d = wdata_q;
		wr_d = 1'b0;
		tmo_off_d = tmo_off_q;
		locked_d = locked_q;
		idle_d = (rise || fall || st_q == ST_IDLE) ? 32'h0000_0000 : idle_q + 32'h0000_0001;
		if (start_c) begin
			st_d = ST_ADDR; // RQ18
			bit_d = 4'h0;
			nbyte_d = 2'h0;
			sda_oe_d = 1'b0;
		end else if (stop_c || (!tmo_off_q && idle_q >= TIMEOUT_CYC)) begin // RQ20 RQ21
			st_d = ST_IDLE;
			sda_oe_d = 1'b0;
		end else if (rise && st_q inside {ST_ADDR, ST_WRX}) begin
			sh_d = {sh_q[6:0], sda};
			bit_d = bit_q + 4'h1;
			// Eighth rising edge of a matching address byte locks it
			if (st_q == ST_ADDR && bit_q == 4'h7 && sh_d[7:1] == addr_q)
				locked_d = 1'b1; // RQ5
		end else if (rise && st_q == ST_RACK) begin
			st_d = sda ? ST_IGN : ST_TX; // RQ9
			bit_d = 4'h0;
			sh_d = reg_rdata;
		end else if (fall) begin
			unique case (st_q)
				ST_ADDR, ST_WRX: begin
					if (bit_q == 4'(smt_pkg::BITS_PER_BYTE)) begin // RQ6
						st_d = ST_ACK;
						if (st_q == ST_ADDR) begin
							rd_d = sh_q[0]; // RQ10
							sda_oe_d = sh_q[7:1] == addr_q; // RQ22
							if (sh_q[7:1] != addr_q)
								st_d = ST_IGN;
						end else begin
							sda_oe_d = nbyte_q != 2'h2; // RQ11
							if (nbyte_q == 2'h0)
								ptr_d = sh_q; // RQ12 RQ14 RQ15
							else if (nbyte_q == 2'h1) begin
								wdata_d = sh_q; // RQ13 RQ14
								wr_d = 1'b1; // RQ19
								if (ptr_q == smt_pkg::CFG1_INDEX)
									tmo_off_d = sh_q[smt_pkg::TMO_OFF_BIT]; // RQ21
							end
							if (nbyte_q != 2'h2)
								nbyte_d = nbyte_q + 2'h1;
						end
					end
				end
				ST_ACK: begin
					bit_d = 4'h0;
					if (rd_q && sda_oe_q && nbyte_q == 2'h0) begin
						st_d = ST_TX; // RQ16 RQ17
						sh_d = reg_rdata;
						nbyte_d = 2'h1;
						sda_oe_d = !reg_rdata[7];
						bit_d = 4'h1;
					end else begin
						st_d = ST_WRX;
						sda_oe_d = 1'b0;
					end
				end
				ST_TX: begin
					if (bit_q == 4'(smt_pkg::BITS_PER_BYTE)) begin
						st_d = ST_RACK;
						sda_oe_d = 1'b0;
					end else begin
						sda_oe_d = !sh_q[7 - 3'(bit_q)]; // RQ7
						bit_d = bit_q + 4'h1;
					end
				end
				default: ;
			endcase
		end
		if (st_q == ST_TX && nbyte_q == 2'h1 && fall && bit_q == 4'h8)
			st_d = ST_IGN; // RQ11
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_q <= smt_pkg::ADDR_FIXED;
			locked_q <= 1'b0;
			st_q <= ST_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			nbyte_q <= 2'h0;
			rd_q <= 1'b0;
			sda_oe_q <= 1'b0;
			ptr_q <= 8'h00;
			wdata_q <= 8'h00;
			wr_q <= 1'b0;
			tmo_off_q <= 1'b0;
			idle_q <= 32'h0000_0000;
		end else begin
			addr_q <= addr_d;
			locked_q <= locked_d;
			st_q <= st_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			nbyte_q <= nbyte_d;
			rd_q <= rd_d;
			sda_oe_q <= sda_oe_d;
			ptr_q <= ptr_d;
			wdata_q <= wdata_d;
			wr_q <= wr_d;
			tmo_off_q <= tmo_off_d;
			idle_q <= idle_d;
		end
	end

	assign bus.sda_t_o = 1'b0;
	assign bus.sda_t_oe = sda_oe_q;
	assign reg_ptr = ptr_q;
	assign reg_wr = wr_q;
	assign reg_wdata = wdata_q;
	assign own_addr = addr_q;
endmodule

// file: include/smt_bus_if.sv
// Two-wire bus joining the target and the master
interface smt_bus_if;
	logic scl_o;
	logic scl_oe;
	logic sda_t_o;
	logic sda_t_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic scl;
	logic sda;
	assign scl = scl_oe ? scl_o : 1'b1;
	assign sda = (sda_t_oe && !sda_t_o) || (sda_m_oe && !sda_m_o) ? 1'b0 : 1'b1;
	modport target (input scl, input sda, output sda_t_o, output sda_t_oe);
	modport master (input scl, input sda, output scl_o, output scl_oe,
		output sda_m_o, output sda_m_oe);
endinterface

// file: include/smt_pkg.sv
// Shared constants for the SMBus target register port and its master
package smt_pkg;
	localparam logic [6:0] ADDR_FIXED = 7'h2E;
	localparam logic [6:0] ADDR_SEL_LO = 7'h2C;
	localparam logic [6:0] ADDR_SEL_HI = 7'h2D;
	localparam int CLK_HZ = 40_000_000;
	localparam int TIMEOUT_MS = 35;
	// Longest time, so rounded down
	localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
	localparam int BITS_PER_BYTE = 8;
	localparam logic [7:0] CFG1_INDEX = 8'h40;
	localparam int TMO_OFF_BIT = 6;
	localparam int SCL_HALF_CYC = 100;
endpackage

// file: tb/smbus_target_register_port_tb.sv
// Self-checking bench joining the SMBus master and target
module smbus_target_register_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TO_CYC = 2000;
	localparam logic [6:0] A_HI = smt_pkg::ADDR_SEL_HI;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic s_en = 1'b0;
	logic s_sel = 1'b1;
	logic req = 1'b0;
	logic [6:0] r_addr = 7'h00;
	logic r_rd = 1'b0;
	logic [1:0] r_nb = 2'h1;
	logic r_rs = 1'b0;
	logic [7:0] r_b0 = 8'h00;
	logic [7:0] r_b1 = 8'h00;
	logic [7:0] reg_rdata, reg_ptr, reg_wdata, rdata;
	logic reg_wr, busy, done, nack;
	logic [6:0] own_addr;
	logic [7:0] regs [256];
	int wr_n = 0;
	int bad_count = 0;
	int n_compared = 0;
	always #12.5 ref_clk = ~ref_clk;
	smt_bus_if bus_a ();
	smt_target #(.SELECTABLE(1'b1), .TIMEOUT_CYC(TO_CYC)) i_smt_target (.ref_clk(ref_clk),
		.arst_n(arst_n), .bus(bus_a.target), .address_strap_enable(s_en),
		.addr_select_strap(s_sel), .reg_rdata(reg_rdata), .reg_ptr(reg_ptr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .own_addr(own_addr));
	smt_master i_smt_master (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus_a.master),
		.req(req), .req_addr(r_addr), .req_rd(r_rd), .req_nbytes(r_nb), .req_rstart(r_rs),
		.req_b0(r_b0), .req_b1(r_b1), .busy(busy), .done(done), .nack(nack), .rdata(rdata));
	smt_bus_properties #(.TIMEOUT_CYC(TO_CYC)) i_smt_bus_properties (.ref_clk(ref_clk),
		.arst_n(arst_n), .scl(bus_a.scl), .sda(bus_a.sda), .sda_t_o(bus_a.sda_t_o),
		.sda_t_oe(bus_a.sda_t_oe));
	assign reg_rdata = regs[reg_ptr];
	always @(posedge ref_clk) begin
		if (reg_wr === 1'b1) begin
			regs[reg_ptr] <= reg_wdata;
			wr_n <= wr_n + 1;
		end
	end
	task automatic check(input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic xfer(input logic [6:0] a, input logic rd, input logic [1:0] nb,
		input logic rs, input logic [7:0] b0, input logic [7:0] b1);
		int i;
		@(posedge ref_clk);
		req <= 1'b1;
		r_addr <= a;
		r_rd <= rd;
		r_nb <= nb;
		r_rs <= rs;
		r_b0 <= b0;
		r_b1 <= b1;
		@(posedge ref_clk);
		req <= 1'b0;
		for (i = 0; i < 10000; i++) begin
			@(posedge ref_clk);
			if (done === 1'b1) break;
		end
		check(8'h01, {7'h00, done});
		check(8'h00, {7'h00, busy});
	endtask
	task automatic reset_with(input logic en, input logic sel);
		@(posedge ref_clk);
		arst_n <= 1'b0;
		s_en <= en;
		s_sel <= sel;
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge ref_clk);
		bad_count++;
		end_of_test();
	end
	initial begin
		reset_with(1'b0, 1'b1);
		xfer(smt_pkg::ADDR_SEL_LO, 1'b0, 2'h2, 1'b0, 8'h10, 8'h77);
		check(8'h01, {7'h00, nack});
		check(8'h00, 8'(wr_n));
		xfer(A_HI, 1'b0, 2'h2, 1'b0, 8'h10, 8'ha5);
		check(8'h00, {7'h00, nack});
		check(8'h10, reg_ptr);
		check(8'ha5, regs[8'h10]);
		check({1'b0, A_HI}, {1'b0, own_addr});
		$display("test strap_select done");
		s_sel <= 1'b0;
		xfer(A_HI, 1'b0, 2'h1, 1'b0, 8'h20, 8'hff);
		check(8'h00, {7'h00, nack});
		check(8'h20, reg_ptr);
		check(8'h01, 8'(wr_n));
		$display("test pointer_only done");
		regs[8'h20] <= 8'h3c;
		xfer(A_HI, 1'b1, 2'h1, 1'b0, 8'h00, 8'h00);
		check(8'h3c, rdata);
		xfer(A_HI, 1'b1, 2'h1, 1'b0, 8'h00, 8'h00);
		check(8'h3c, rdata);
		xfer(A_HI, 1'b0, 2'h1, 1'b1, 8'h10, 8'h00);
		xfer(A_HI, 1'b1, 2'h1, 1'b0, 8'h00, 8'h00);
		check(8'ha5, rdata);
		$display("test read done");
		reset_with(1'b1, 1'b0);
		s_en <= 1'b0;
		xfer(A_HI, 1'b0, 2'h2, 1'b0, 8'h11, 8'h5a);
		check(8'h01, {7'h00, nack});
		xfer(smt_pkg::ADDR_FIXED, 1'b0, 2'h2, 1'b0, 8'h11, 8'h5a);
		check(8'h00, {7'h00, nack});
		check(8'h5a, regs[8'h11]);
		$display("test fixed_address done");
		end_of_test();
	end
endmodule

// file: tb/smt_bus_properties.sv
// Bus-level checks of the SMBus target as seen on the shared wires
module smt_bus_properties #(
	parameter int TIMEOUT_CYC = 2000
) (
	input wire logic ref_clk, // Clock
	input wire logic arst_n, // Async reset
	input wire logic scl, // Resolved clock wire
	input wire logic sda, // Resolved data wire
	input wire logic sda_t_o, // Target data drive
	input wire logic sda_t_oe // Target pulls data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic scl_q, sda_q, xfer_q, xfer_d, rd_q, rd_d;
	logic start, stop, rise;
	logic [4:0] cnt_q, cnt_d;
	int stall_q, stall_d;
	always_comb begin
		start = scl && scl_q && sda_q && !sda;
		stop = scl && scl_q && !sda_q && sda;
		rise = scl && !scl_q;
		xfer_d = xfer_q;
		cnt_d = cnt_q;
		rd_d = rd_q;
		if (start || stop) begin
			xfer_d = start;
			cnt_d = 5'h00;
		end else if (rise && cnt_q != 5'h1f) begin
			cnt_d = cnt_q + 5'h01;
			if (cnt_q == 5'h07) rd_d = sda;
		end
		stall_d = (sda_t_oe && scl == scl_q) ? stall_q + 1 : 0;
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			xfer_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= 5'h00;
			stall_q <= 0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			xfer_q <= xfer_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			stall_q <= stall_d;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	a_target_pulls_low: assert property (sda_t_oe |-> !sda_t_o)
		else $error("target drives data high");
	a_read_drive_slot: assert property (scl && scl_q && sda_t_oe && rd_q |->
		cnt_q inside {[5'h09:5'h11]})
		else $error("target drove outside a read acknowledge or data slot");
	a_stable_clk_high: assert property (scl && scl_q |-> $stable(sda_t_oe))
		else $error("target data moved while clock high");
	a_write_ack_slot: assert property (scl && scl_q && sda_t_oe && !rd_q |->
		cnt_q inside {5'h09, 5'h12, 5'h1b})
		else $error("target drove outside a write acknowledge slot");
	a_nack_slot_high: assert property (scl && scl_q && rd_q && xfer_q && cnt_q == 5'h12 |-> sda)
		else $error("read acknowledge slot not high");
	a_pulse_limit: assert property (xfer_q |-> cnt_q <= (rd_q ? 5'h13 : 5'h1c))
		else $error("too many clock pulses in one transfer");
	a_idle_released: assert property (!xfer_q |-> !sda_t_oe)
		else $error("target drives data outside a transfer");
	a_scl_low_min: assert property ($fell(scl) |=> !scl [*8])
		else $error("clock low phase too short");
	a_scl_high_min: assert property ($rose(scl) |=> scl [*8])
		else $error("clock high phase too short");
	a_timeout_bound: assert property (stall_q <= TIMEOUT_CYC + 8)
		else $error("target held data past the timeout");
	c_addr_write: cover property (rise && cnt_q == 5'h07 && !sda);
	c_read_data: cover property (scl && rd_q && cnt_q == 5'h0a && sda_t_oe);
	c_stop: cover property (stop);
endmodule
